// [core/prc_pkg.sv]
// Package: addresses, reset values and field positions of the reset control registers
package prc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned STRB_W = DATA_W / BYTE_W;
  localparam int unsigned RB_W = 12;
  localparam int unsigned SYNC_STAGES = 2;

  localparam logic [31:0] ADDR_CTRL_A = 32'h4000b004;
  localparam logic [31:0] ADDR_CTRL_B = 32'h4000b008;
  localparam logic [31:0] ADDR_STAT_A = 32'h4000b044;
  localparam logic [31:0] ADDR_STAT_B = 32'h4000b048;

  localparam logic [31:0] RST_CTRL_A = 32'hfffffffd;
  localparam logic [11:0] RST_CTRL_B = 12'hfff;

  // First register, field positions
  localparam int unsigned A_PG3 = 31;
  localparam int unsigned A_PG2 = 30;
  localparam int unsigned A_PG1 = 29;
  localparam int unsigned A_PG0 = 28;
  localparam int unsigned A_QD2 = 27;
  localparam int unsigned A_QD1 = 26;
  localparam int unsigned A_QD0 = 25;
  localparam int unsigned A_CPB = 24;
  localparam int unsigned A_FRC = 23;
  localparam int unsigned A_DBG = 22;
  localparam int unsigned A_CXB = 21;
  localparam int unsigned A_CAL = 20;
  localparam int unsigned A_MST = 19;
  localparam int unsigned A_IRQ = 18;
  localparam int unsigned A_WD1 = 17;
  localparam int unsigned A_WD0 = 16;
  localparam int unsigned A_AP1I = 15;
  localparam int unsigned A_AP1C = 14;
  localparam int unsigned A_AP0I = 13;
  localparam int unsigned A_AP0C = 12;
  localparam int unsigned A_TMR = 11;
  localparam int unsigned A_PIN = 10;
  localparam int unsigned A_TW0I = 9;
  localparam int unsigned A_TW0C = 8;
  localparam int unsigned A_SP1I = 7;
  localparam int unsigned A_SP1C = 6;
  localparam int unsigned A_SP0I = 5;
  localparam int unsigned A_SP0C = 4;
  localparam int unsigned A_FLI = 3;
  localparam int unsigned A_FLS = 2;
  localparam int unsigned A_CPU = 1;
  localparam int unsigned A_GLB = 0;

  // Second register, field positions
  localparam int unsigned B_DMA = 11;
  localparam int unsigned B_SP1P = 10;
  localparam int unsigned B_SP0P = 9;
  localparam int unsigned B_SP1M = 8;
  localparam int unsigned B_SP0M = 7;
  localparam int unsigned B_CIB = 6;
  localparam int unsigned B_CIE = 5;
  localparam int unsigned B_HSB = 4;
  localparam int unsigned B_HSE = 3;
  localparam int unsigned B_TW1I = 2;
  localparam int unsigned B_TW1C = 1;
  localparam int unsigned B_PTM = 0;

endpackage

// [core/prc_rst_sync.sv]
// Reset synchroniser bank: immediate assertion, clocked release per field
`timescale 1ns/100ps
module prc_rst_sync #(
  parameter int unsigned WIDTH = 44,
  parameter int unsigned STAGES = prc_pkg::SYNC_STAGES
) (
  input wire logic clk, // Clock of the released logic
  input wire logic [WIDTH-1:0] req_n, // Reset request, low holds reset
  output logic [WIDTH-1:0] rel_n // Synchronised reset, low in reset
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [STAGES-1:0] stage;
      // Assertion bypasses the clock; release walks the chain so it never glitches
      always_ff @(posedge clk or negedge req_n[i]) begin
        if (!req_n[i]) begin
          stage <= '0;
        end else begin
          stage <= {stage[STAGES-2:0], 1'b1};
        end
      end
      assign rel_n[i] = stage[STAGES-1];
    end
  endgenerate

endmodule // prc_rst_sync

// [core/prc_reset_ctrl.sv]
// Peripheral soft reset controller with APB register access
`timescale 1ns/100ps
module prc_reset_ctrl (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high writes
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic pulse_gen_c3_reset_n, // Pulse generator 3
  output logic pulse_gen_c2_reset_n, // Pulse generator 2
  output logic pulse_gen_c1_reset_n, // Pulse generator 1
  output logic pulse_gen_c0_reset_n, // Pulse generator 0
  output logic quadrature_unit2_reset_n, // Quadrature decoder 2
  output logic quadrature_unit1_reset_n, // Quadrature decoder 1
  output logic quadrature_unit0_reset_n, // Quadrature decoder 0
  output logic cpu_periph_bus_reset_n, // Processor peripheral bus
  output logic cpu_freerun_clock_reset_n, // Processor free clock logic
  output logic debug_logic_reset_n, // Debug logic
  output logic calibration_crossbar_reset_n, // Calibration crossbar
  output logic calibration_reset_n, // Calibration logic
  output logic memory_selftest_reset_n, // Memory self-test
  output logic interrupt_ctrl_reset_n, // Interrupt controller
  output logic watchdog_unit1_reset_n, // Watchdog 1
  output logic watchdog_unit0_reset_n, // Watchdog 0
  output logic async_port1_iface_reset_n, // Async port 1 interface
  output logic async_port1_core_reset_n, // Async port 1 core
  output logic async_port0_iface_reset_n, // Async port 0 interface
  output logic async_port0_core_reset_n, // Async port 0 core
  output logic general_timer_a_reset_n, // General timer 0
  output logic pin_controller_reset_n, // Pin controllers
  output logic twowire0_iface_reset_n, // Two-wire 0 interface
  output logic twowire0_core_reset_n, // Two-wire 0 core
  output logic serport1_iface_reset_n, // Serial port 1 interface
  output logic serport1_core_reset_n, // Serial port 1 core
  output logic serport0_iface_reset_n, // Serial port 0 interface
  output logic serport0_core_reset_n, // Serial port 0 core
  output logic flash_port_iface_reset_n, // Flash port interface
  output logic flash_port_sysbus_reset_n, // Flash port system bus
  output logic processor_reset_n, // Processor
  output logic whole_chip_reset_n, // Global reset
  output logic dma_controller_reset_n, // DMA controller
  output logic serport1_phase_clk_reset_n, // Serial port 1 phase clock
  output logic serport0_phase_clk_reset_n, // Serial port 0 phase clock
  output logic serport1_master_clk_reset_n, // Serial port 1 master clock
  output logic serport0_master_clk_reset_n, // Serial port 0 master clock
  output logic cipher_bus_reset_n, // Cipher bus side
  output logic cipher_engine_reset_n, // Cipher engine
  output logic hash_bus_reset_n, // Hash bus side
  output logic hash_engine_reset_n, // Hash engine
  output logic twowire1_iface_reset_n, // Two-wire 1 interface
  output logic twowire1_core_reset_n, // Two-wire 1 core
  output logic paired_timer_reset_n // Paired timer
);

  localparam int unsigned DW = prc_pkg::DATA_W;
  localparam int unsigned BW = prc_pkg::RB_W;
  localparam int unsigned NF = DW + BW;

  // Byte-lane merge, shared by both writable registers
  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0] old_v,
    input logic [DW-1:0] new_v,
    input logic [prc_pkg::STRB_W-1:0] strb
  );
    logic [DW-1:0] r;
    r = old_v;
    for (int k = 0; k < prc_pkg::STRB_W; k++) begin
      if (strb[k]) begin
        r[k*prc_pkg::BYTE_W +: prc_pkg::BYTE_W] = new_v[k*prc_pkg::BYTE_W +: prc_pkg::BYTE_W];
      end
    end
    return r;
  endfunction

  logic [DW-1:0] ctrl_a;
  logic [BW-1:0] ctrl_b;
  logic [DW-1:0] next_ctrl_a;
  logic [BW-1:0] next_ctrl_b;
  logic [DW-1:0] next_prdata;
  logic next_pslverr;
  logic [NF-1:0] rel_n;
  logic [DW-1:0] rel_a;
  logic [BW-1:0] rel_b;

  // Address decode
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire hit_a = (paddr == prc_pkg::ADDR_CTRL_A);
  wire hit_b = (paddr == prc_pkg::ADDR_CTRL_B);
  wire hit_sa = (paddr == prc_pkg::ADDR_STAT_A);
  wire hit_sb = (paddr == prc_pkg::ADDR_STAT_B);
  wire hit_any = hit_a | hit_b | hit_sa | hit_sb;
  wire wr_a = access_ph & pwrite & hit_a;
  wire wr_b = access_ph & pwrite & hit_b;

  // Write path
  wire [DW-1:0] ctrl_b_ext = {{(DW-BW){1'b0}}, ctrl_b};
  wire [DW-1:0] rel_b_ext = {{(DW-BW){1'b0}}, rel_b};
  wire [DW-1:0] mrg_a = lane_merge(ctrl_a, pwdata, pstrb);
  wire [DW-1:0] mrg_b = lane_merge(ctrl_b_ext, pwdata, pstrb);
  assign next_ctrl_a = wr_a ? mrg_a : ctrl_a;
  assign next_ctrl_b = wr_b ? mrg_b[BW-1:0] : ctrl_b;

  // Read path; status words show which units have actually left reset
  wire [DW-1:0] rd_ctrl = hit_a ? ctrl_a : (hit_b ? ctrl_b_ext : '0);
  wire [DW-1:0] rd_stat = hit_sa ? rel_a : (hit_sb ? rel_b_ext : '0);
  assign next_prdata = (setup_ph & ~pwrite) ? (rd_ctrl | rd_stat) : '0;
  assign next_pslverr = setup_ph & ~hit_any;

  // Zero wait states: data is staged in the setup cycle
  assign pready = access_ph;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a <= prc_pkg::RST_CTRL_A;
      ctrl_b <= prc_pkg::RST_CTRL_B;
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Power-on reset also holds every unit; only pclk exists here, so the
  // serial clock domains must re-synchronise this release on their side
  wire [NF-1:0] req_n = {ctrl_b, ctrl_a} & {NF{presetn}};

  prc_rst_sync #(
    .WIDTH(NF),
    .STAGES(prc_pkg::SYNC_STAGES)
  ) u_sync (
    .clk(pclk),
    .req_n(req_n),
    .rel_n(rel_n)
  );

  assign rel_a = rel_n[DW-1:0];
  assign rel_b = rel_n[NF-1:DW];

  // Pulse generators and quadrature decoders
  assign pulse_gen_c3_reset_n = rel_a[prc_pkg::A_PG3];
  assign pulse_gen_c2_reset_n = rel_a[prc_pkg::A_PG2];
  assign pulse_gen_c1_reset_n = rel_a[prc_pkg::A_PG1];
  assign pulse_gen_c0_reset_n = rel_a[prc_pkg::A_PG0];
  assign quadrature_unit2_reset_n = rel_a[prc_pkg::A_QD2];
  assign quadrature_unit1_reset_n = rel_a[prc_pkg::A_QD1];
  assign quadrature_unit0_reset_n = rel_a[prc_pkg::A_QD0];

  // Boot-managed fields stay writable; firmware is trusted to keep them
  assign cpu_periph_bus_reset_n = rel_a[prc_pkg::A_CPB];
  assign cpu_freerun_clock_reset_n = rel_a[prc_pkg::A_FRC];
  assign debug_logic_reset_n = rel_a[prc_pkg::A_DBG];
  assign calibration_crossbar_reset_n = rel_a[prc_pkg::A_CXB];
  assign calibration_reset_n = rel_a[prc_pkg::A_CAL];
  assign memory_selftest_reset_n = rel_a[prc_pkg::A_MST];
  assign interrupt_ctrl_reset_n = rel_a[prc_pkg::A_IRQ];
  assign processor_reset_n = rel_a[prc_pkg::A_CPU];
  assign whole_chip_reset_n = rel_a[prc_pkg::A_GLB];

  // Watchdogs, async ports, timer, pins
  assign watchdog_unit1_reset_n = rel_a[prc_pkg::A_WD1];
  assign watchdog_unit0_reset_n = rel_a[prc_pkg::A_WD0];
  assign async_port1_iface_reset_n = rel_a[prc_pkg::A_AP1I];
  assign async_port1_core_reset_n = rel_a[prc_pkg::A_AP1C];
  assign async_port0_iface_reset_n = rel_a[prc_pkg::A_AP0I];
  assign async_port0_core_reset_n = rel_a[prc_pkg::A_AP0C];
  assign general_timer_a_reset_n = rel_a[prc_pkg::A_TMR];
  assign pin_controller_reset_n = rel_a[prc_pkg::A_PIN];

  // Two-wire 0, serial ports, flash port
  assign twowire0_iface_reset_n = rel_a[prc_pkg::A_TW0I];
  assign twowire0_core_reset_n = rel_a[prc_pkg::A_TW0C];
  assign serport1_iface_reset_n = rel_a[prc_pkg::A_SP1I];
  assign serport1_core_reset_n = rel_a[prc_pkg::A_SP1C];
  assign serport0_iface_reset_n = rel_a[prc_pkg::A_SP0I];
  assign serport0_core_reset_n = rel_a[prc_pkg::A_SP0C];
  assign flash_port_iface_reset_n = rel_a[prc_pkg::A_FLI];
  assign flash_port_sysbus_reset_n = rel_a[prc_pkg::A_FLS];

  // Second register
  assign dma_controller_reset_n = rel_b[prc_pkg::B_DMA];
  assign serport1_phase_clk_reset_n = rel_b[prc_pkg::B_SP1P];
  assign serport0_phase_clk_reset_n = rel_b[prc_pkg::B_SP0P];
  assign serport1_master_clk_reset_n = rel_b[prc_pkg::B_SP1M];
  assign serport0_master_clk_reset_n = rel_b[prc_pkg::B_SP0M];
  assign cipher_bus_reset_n = rel_b[prc_pkg::B_CIB];
  assign cipher_engine_reset_n = rel_b[prc_pkg::B_CIE];
  assign hash_bus_reset_n = rel_b[prc_pkg::B_HSB];
  assign hash_engine_reset_n = rel_b[prc_pkg::B_HSE];
  assign twowire1_iface_reset_n = rel_b[prc_pkg::B_TW1I];
  assign twowire1_core_reset_n = rel_b[prc_pkg::B_TW1C];
  assign paired_timer_reset_n = rel_b[prc_pkg::B_PTM];

endmodule // prc_reset_ctrl

// [sim/prc_reset_ctrl_monitor.sv]
// Checker: reset output timing against APB writes and reads
`timescale 1ns/100ps
module prc_reset_ctrl_monitor (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [31:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Byte strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pulse_gen_c3_reset_n, // Pulse generator 3
  input wire logic quadrature_unit0_reset_n, // Quadrature 0
  input wire logic watchdog_unit0_reset_n, // Watchdog 0
  input wire logic general_timer_a_reset_n, // Timer 0
  input wire logic flash_port_sysbus_reset_n, // Flash system bus
  input wire logic dma_controller_reset_n, // DMA
  input wire logic serport0_master_clk_reset_n, // Serial port 0 clock
  input wire logic twowire1_iface_reset_n // Two-wire 1 interface
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr_a = acc && pwrite && paddr == prc_pkg::ADDR_CTRL_A;
  wire wr_b = acc && pwrite && paddr == prc_pkg::ADDR_CTRL_B;
  wire rd_b = acc && !pwrite && paddr == prc_pkg::ADDR_CTRL_B;
  // Release source: a write of one, or power-on reset three cycles back, may explain a rising DMA reset line
  wire wr_dma1 = wr_b && pstrb[1] && pwdata[11];
  property p_pg3_fall; wr_a && pstrb[3] && !pwdata[31] |=> !pulse_gen_c3_reset_n; endproperty
  a_pg3_fall: assert property (p_pg3_fall) else $error("pulse gen 3 not held");
  property p_pg3_rel; wr_a && pstrb[3] && pwdata[31] ##1 !wr_a [*2] |=> pulse_gen_c3_reset_n;
  endproperty
  a_pg3_rel: assert property (p_pg3_rel) else $error("pulse gen 3 not released");
  property p_quad0; wr_a && pstrb[3] && !pwdata[25] |=> !quadrature_unit0_reset_n; endproperty
  a_quad0: assert property (p_quad0) else $error("quadrature 0 not held");
  property p_wd0; wr_a && pstrb[2] && !pwdata[16] |=> !watchdog_unit0_reset_n [*2]; endproperty
  a_wd0: assert property (p_wd0) else $error("watchdog 0 not held");
  property p_tmr; wr_a && pstrb[1] && !pwdata[11] |=> !general_timer_a_reset_n; endproperty
  a_tmr: assert property (p_tmr) else $error("timer 0 not held");
  property p_flash; wr_a && pstrb[0] && !pwdata[2] |=> !flash_port_sysbus_reset_n; endproperty
  a_flash: assert property (p_flash) else $error("flash bus side not held");
  property p_dma_rel;
    $rose(dma_controller_reset_n) |-> !$past(presetn, 3) || $past(wr_dma1, 3);
  endproperty
  a_dma_rel: assert property (p_dma_rel) else $error("DMA release not synchronised");
  property p_sp0m; wr_b && pstrb[0] && !pwdata[7] |=> !serport0_master_clk_reset_n; endproperty
  a_sp0m: assert property (p_sp0m) else $error("serial 0 clock logic not held");
  property p_tw1; wr_b && pstrb[0] && !pwdata[2] |=> !twowire1_iface_reset_n; endproperty
  a_tw1: assert property (p_tw1) else $error("two-wire 1 not held");
  property p_b_upper; rd_b |-> prdata[31:12] == 20'h0; endproperty
  a_b_upper: assert property (p_b_upper) else $error("upper bits of second register set");
endmodule // prc_reset_ctrl_monitor

bind prc_reset_ctrl prc_reset_ctrl_monitor i_prc_reset_ctrl_monitor (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pulse_gen_c3_reset_n,
  .quadrature_unit0_reset_n, .watchdog_unit0_reset_n, .general_timer_a_reset_n,
  .flash_port_sysbus_reset_n, .dma_controller_reset_n, .serport0_master_clk_reset_n,
  .twowire1_iface_reset_n);

// [sim/testbench.sv]
// Testbench: APB access to both reset registers and checks of all reset lines
`timescale 1ns/100ps
module testbench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  wire [31:0] oa;
  wire [11:0] ob;
  logic pready, pslverr;
  int bad_count = 0, total_checks = 0;
  always #12.5 pclk = ~pclk;
  prc_reset_ctrl i_prc_reset_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_gen_c3_reset_n(oa[31]), .pulse_gen_c2_reset_n(oa[30]),
    .pulse_gen_c1_reset_n(oa[29]), .pulse_gen_c0_reset_n(oa[28]),
    .quadrature_unit2_reset_n(oa[27]), .quadrature_unit1_reset_n(oa[26]),
    .quadrature_unit0_reset_n(oa[25]), .cpu_periph_bus_reset_n(oa[24]),
    .cpu_freerun_clock_reset_n(oa[23]), .debug_logic_reset_n(oa[22]),
    .calibration_crossbar_reset_n(oa[21]), .calibration_reset_n(oa[20]),
    .memory_selftest_reset_n(oa[19]), .interrupt_ctrl_reset_n(oa[18]),
    .watchdog_unit1_reset_n(oa[17]), .watchdog_unit0_reset_n(oa[16]),
    .async_port1_iface_reset_n(oa[15]), .async_port1_core_reset_n(oa[14]),
    .async_port0_iface_reset_n(oa[13]), .async_port0_core_reset_n(oa[12]),
    .general_timer_a_reset_n(oa[11]), .pin_controller_reset_n(oa[10]),
    .twowire0_iface_reset_n(oa[9]), .twowire0_core_reset_n(oa[8]),
    .serport1_iface_reset_n(oa[7]), .serport1_core_reset_n(oa[6]),
    .serport0_iface_reset_n(oa[5]), .serport0_core_reset_n(oa[4]),
    .flash_port_iface_reset_n(oa[3]), .flash_port_sysbus_reset_n(oa[2]),
    .processor_reset_n(oa[1]), .whole_chip_reset_n(oa[0]),
    .dma_controller_reset_n(ob[11]), .serport1_phase_clk_reset_n(ob[10]),
    .serport0_phase_clk_reset_n(ob[9]), .serport1_master_clk_reset_n(ob[8]),
    .serport0_master_clk_reset_n(ob[7]), .cipher_bus_reset_n(ob[6]),
    .cipher_engine_reset_n(ob[5]), .hash_bus_reset_n(ob[4]), .hash_engine_reset_n(ob[3]),
    .twowire1_iface_reset_n(ob[2]), .twowire1_core_reset_n(ob[1]),
    .paired_timer_reset_n(ob[0]));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One idle cycle after each transfer keeps psel from being assigned twice in one step
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] s);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic toggle(logic b, int i);
    logic [31:0] a, base, d;
    a = b ? prc_pkg::ADDR_CTRL_B : prc_pkg::ADDR_CTRL_A;
    base = b ? {20'h0, prc_pkg::RST_CTRL_B} : prc_pkg::RST_CTRL_A;
    d = base & ~(32'h1 << i);
    xfer(1'h1, a, d, 4'hf);
    @(negedge pclk);
    check("field held low", b ? {20'h0, ob} : oa, d);
    @(posedge pclk);
    xfer(1'h0, a, 32'h0, 4'h0);
    check("field read", rd, d);
    xfer(1'h1, a, base, 4'hf);
    // Sampled mid-cycle: one edge after the write the line must still be low
    @(negedge pclk);
    check("release not early", b ? {20'h0, ob} : oa, d);
    @(negedge pclk);
    check("field released", b ? {20'h0, ob} : oa, base);
    @(posedge pclk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    check("held after release", oa, 32'h0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("outputs a", oa, prc_pkg::RST_CTRL_A);
    check("outputs b", {20'h0, ob}, {20'h0, prc_pkg::RST_CTRL_B});
    @(posedge pclk);
    xfer(1'h0, prc_pkg::ADDR_CTRL_A, 32'h0, 4'h0);
    check("read a", rd, prc_pkg::RST_CTRL_A);
    check("mapped err", {31'h0, er}, 32'h0);
    xfer(1'h0, prc_pkg::ADDR_CTRL_B, 32'h0, 4'h0);
    check("read b", rd, {20'h0, prc_pkg::RST_CTRL_B});
    xfer(1'h0, prc_pkg::ADDR_STAT_A, 32'h0, 4'h0);
    check("status a", rd, prc_pkg::RST_CTRL_A);
    xfer(1'h0, prc_pkg::ADDR_STAT_B, 32'h0, 4'h0);
    check("status b", rd, {20'h0, prc_pkg::RST_CTRL_B});
    // Boot-managed fields are left alone, as software is asked to
    for (int i = 2; i < 32; i++) begin
      if (i < 18 || i > 24) begin
        toggle(1'h0, i);
      end
    end
    for (int i = 0; i < 12; i++) begin
      if (i < 3 || i > 6) begin
        toggle(1'h1, i);
      end
    end
    // Only the watchdog byte is strobed; the boot-managed bits in it keep their value
    xfer(1'h1, prc_pkg::ADDR_CTRL_A, 32'h00fc0000, 4'h4);
    xfer(1'h0, prc_pkg::ADDR_CTRL_A, 32'h0, 4'h0);
    check("strobe read", rd, prc_pkg::RST_CTRL_A & 32'hfffcffff);
    check("strobe out", oa, prc_pkg::RST_CTRL_A & 32'hfffcffff);
    xfer(1'h1, prc_pkg::ADDR_CTRL_A, prc_pkg::RST_CTRL_A, 4'hf);
    xfer(1'h1, prc_pkg::ADDR_CTRL_B, 32'hfffff078, 4'hf);
    xfer(1'h0, prc_pkg::ADDR_CTRL_B, 32'h0, 4'h0);
    check("b upper", rd, 32'h00000078);
    check("b out", {20'h0, ob}, 32'h00000078);
    xfer(1'h1, prc_pkg::ADDR_CTRL_B, 32'h00000fff, 4'hf);
    xfer(1'h0, 32'h4000b00c, 32'h0, 4'h0);
    check("unmapped err", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    xfer(1'h0, prc_pkg::ADDR_CTRL_B, 32'h0, 4'h0);
    check("b restore", rd, 32'h00000fff);
    xfer(1'h1, prc_pkg::ADDR_CTRL_A, 32'h01fc0001, 4'hf);
    presetn <= 1'h0;
    @(negedge pclk);
    check("reset out", oa, 32'h0);
    check("reset out b", {20'h0, ob}, 32'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    check("held after reset", oa, 32'h0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("reset again", oa, prc_pkg::RST_CTRL_A);
    @(posedge pclk);
    xfer(1'h0, prc_pkg::ADDR_CTRL_A, 32'h0, 4'h0);
    check("reset reg a", rd, prc_pkg::RST_CTRL_A);
    print_verdict();
  end
endmodule // testbench
